// ===== verilog/cmlb_map.svh
// Register offsets, field positions, reset values and scale constants
`ifndef CMLB_MAP_SVH
`define CMLB_MAP_SVH

// ----------------------------------------
// Percentage scale, 1/256 percent per LSB
// ----------------------------------------
`define CMLB_PCT_FULL 32'sh0000_6400
`define CMLB_PCT_ONE 32'sh0000_0100
`define CMLB_W_SHIFT 14

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define CMLB_MATH_BASE 32'h0000_0000
`define CMLB_MATH_SPAN 32'h0000_0040
`define CMLB_IN_STEP 32'h0000_0008
`define CMLB_IN_CFG 32'h0000_0004
`define CMLB_OPS 32'h0000_0020
`define CMLB_ORNG 32'h0000_0024
`define CMLB_COND_BASE 32'h0000_0080
`define CMLB_LED_BASE 32'h0000_00A0
`define CMLB_LED_SPAN 32'h0000_0010
`define CMLB_WORD 32'h0000_0004
`define CMLB_STAT_MATH 32'h0000_00C0
`define CMLB_STAT_FLAGS 32'h0000_00C4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMLB_F_LO 15:0
`define CMLB_F_HI 31:16
`define CMLB_F_SRC 3:0
`define CMLB_SRC_W 4
`define CMLB_OP_W 4
`define CMLB_F_C1 18:16
`define CMLB_F_C2 22:20
`define CMLB_F_C3 25:24
`define CMLB_F_COUT 1:0
`define CMLB_F_LS0 6:4
`define CMLB_F_LS1 10:8

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define CMLB_LIM_RST 32'h0064_0000
`define CMLB_ICFG_RST 32'h4000_0000
`define CMLB_OPS_RST 32'h0000_0000
`define CMLB_ORNG_RST 32'h0064_0000
`define CMLB_COND_RST 32'h0077_0000
`define CMLB_LED_RST 32'h0064_0000
`define CMLB_RESP_OKAY 2'h0
`define CMLB_RESP_SLVERR 2'h2

`endif

// ===== verilog/cmlb_pkg.sv
// Types shared by the math, conditional and LED evaluation block
`default_nettype none
package cmlb_pkg;

	localparam int N_MATH = 2;
	localparam int N_IN = 4;
	localparam int N_FN = 3;
	localparam int N_COND = 2;
	localparam int N_LED = 2;
	localparam int N_STAGE = 4;
	localparam int N_SRC = 8;
	localparam int N_FAULT = 6;

	typedef enum logic [3:0] {
		OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_OR, OP_AND,
		OP_XOR, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MIN, OP_MAX
	} cmlb_op_t;

	typedef enum logic [2:0] {
		C_EQ, C_NE, C_GT, C_GE, C_LT, C_LE, C_OR, C_AND
	} cmlb_cop_t;

	typedef enum logic [1:0] {CB_OR, CB_AND, CB_XOR} cmlb_comb_t;

	typedef enum logic [2:0] {
		RK_NONE, RK_LIM, RK_CFG, RK_OPS, RK_ORNG, RK_COND, RK_LED, RK_STAT
	} cmlb_rk_t;

	typedef struct packed {
		cmlb_rk_t kind;
		logic blk;
		logic [1:0] idx;
	} cmlb_dec_t;

	typedef logic [N_SRC-1:0][15:0] cmlb_src_t;
	typedef logic [N_FAULT-1:0] cmlb_fault_t;
	typedef logic [N_MATH-1:0][15:0] cmlb_mout_t;
	typedef logic [N_COND-1:0] cmlb_cout_t;
	typedef logic [N_LED-1:0][2:0] cmlb_lstage_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic [2:0] awprot;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic [2:0] arprot;
		logic rready;
	} cmlb_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cmlb_axil_rsp_t;

endpackage : cmlb_pkg
`default_nettype wire

// ===== verilog/cmlb_top.sv
// Math blocks, conditional blocks and LED stage selection behind AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`include "cmlb_map.svh"

// What this block does
// - Two independent math blocks, each with four selectable inputs.
// - Each math input becomes a percentage between its minimum and maximum.
// - Each percentage is weighted by a signed factor from -2.0 to just under 2.0, default 1.0.
// - Functions chain; only the first takes a chosen first operand.
// - A second operand with source zero passes the first operand unchanged.
// - Codes 0-5 compare equal, unequal, greater, greater-equal, less, less-equal.
// - Codes 6, 7, 8 give OR, AND, XOR.
// - Codes 9-14 give add, subtract, multiply, divide, minimum, maximum.
// - A logic operand counts true at one or more.
// - Codes 0-8 give exactly zero or one.
// - Arithmetic results saturate between 0 and 100 percent.
// - Division by zero gives 100 percent.
// - Final percentage maps into the output range of its math block.
// - Conditional block combines two two-input conditions with a third operator.
// - An unselected conditional input reads as zero.
// - Condition codes 0-7 give six comparisons, OR and AND.
// - Both condition operators reset to AND.
// - Combining operator accepts only OR, AND, XOR.
// - Conditional output is only one or zero.
// - Each LED has four numbered stages plus a lowest default stage.
// - Stage source 0 does nothing; 1-6 are fault flags.
// - Stage sources 7-14 activate at or above the stage maximum; source 15 does nothing.
module cmlb_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cmlb_pkg::cmlb_axil_req_t axil_req,
	output var cmlb_pkg::cmlb_axil_rsp_t axil_rsp,
	input wire cmlb_pkg::cmlb_src_t src_val,
	input wire cmlb_pkg::cmlb_fault_t fault_in,
	output var cmlb_pkg::cmlb_mout_t math_out,
	output var cmlb_pkg::cmlb_cout_t cond_out,
	output var cmlb_pkg::cmlb_lstage_t led_stage
);
	import cmlb_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [31:0] lim_ff [N_MATH][N_IN];
	logic [31:0] icfg_ff [N_MATH][N_IN];
	logic [31:0] ops_ff [N_MATH];
	logic [31:0] orng_ff [N_MATH];
	logic [31:0] cond_ff [N_COND];
	logic [31:0] stg_ff [N_LED][N_STAGE];
	cmlb_mout_t math_ff;
	cmlb_cout_t cout_ff;
	cmlb_lstage_t lstage_ff;
	cmlb_axil_rsp_t rsp_ff;
	cmlb_axil_rsp_t nxt_rsp;
	logic aw_have_ff;
	logic w_have_ff;
	logic [31:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		merge = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				merge[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
	endfunction : merge

	function automatic logic [15:0] sel_src(input logic [3:0] code, input cmlb_src_t v);
		sel_src = 16'h0000;
		for (int k = 0; k < N_SRC; k++) begin
			if (code == 4'(k + 1)) begin
				sel_src = v[k];
			end
		end
	endfunction : sel_src

	function automatic int sat(input int r);
		sat = r;
		if (r < 0) begin
			sat = 0;
		end else if (r > `CMLB_PCT_FULL) begin
			sat = `CMLB_PCT_FULL;
		end
	endfunction : sat

	function automatic int to_pct(input logic [15:0] x, input logic [15:0] mn, input logic [15:0] mx);
		logic [31:0] num;
		num = 32'h0000_0000;
		to_pct = 0;
		// Inverted limits read as zero rather than dividing by a negative span
		if (mx > mn && x >= mx) begin
			to_pct = `CMLB_PCT_FULL;
		end else if (mx > mn && x > mn) begin
			num = 32'(x - mn) * 32'(`CMLB_PCT_FULL);
			to_pct = int'(num / 32'(mx - mn));
		end
	endfunction : to_pct

	function automatic int weight(input int p, input logic [15:0] s);
		weight = (p * int'($signed(s))) >>> `CMLB_W_SHIFT;
	endfunction : weight

	function automatic int bool_pct(input logic t);
		bool_pct = t ? `CMLB_PCT_ONE : 0;
	endfunction : bool_pct

	function automatic int math_fn(input int a, input int b, input logic [3:0] op, input logic bused);
		logic ta;
		logic tb;
		ta = (a >= `CMLB_PCT_ONE);
		tb = (b >= `CMLB_PCT_ONE);
		case (cmlb_op_t'(op))
			OP_EQ: math_fn = bool_pct(a == b);
			OP_NE: math_fn = bool_pct(a != b);
			OP_GT: math_fn = bool_pct(a > b);
			OP_GE: math_fn = bool_pct(a >= b);
			OP_LT: math_fn = bool_pct(a < b);
			OP_LE: math_fn = bool_pct(a <= b);
			OP_OR: math_fn = bool_pct(ta | tb);
			OP_AND: math_fn = bool_pct(ta & tb);
			OP_XOR: math_fn = bool_pct(ta ^ tb);
			OP_ADD: math_fn = sat(a + b);
			OP_SUB: math_fn = sat(a - b);
			OP_MUL: math_fn = sat((a * b) / `CMLB_PCT_FULL);
			OP_DIV: math_fn = (b == 0) ? `CMLB_PCT_FULL : sat((a * `CMLB_PCT_FULL) / b);
			OP_MIN: math_fn = sat((a < b) ? a : b);
			OP_MAX: math_fn = sat((a > b) ? a : b);
			default: math_fn = a;
		endcase
		if (!bused) begin
			math_fn = a;
		end
	endfunction : math_fn

	function automatic logic [15:0] to_phys(input int r, input logic [15:0] mn, input logic [15:0] mx);
		int d;
		d = int'(mx) - int'(mn);
		to_phys = 16'(int'(mn) + (sat(r) * d) / `CMLB_PCT_FULL);
	endfunction : to_phys

	function automatic logic cond_cmp(input logic [15:0] a, input logic [15:0] b, input logic [2:0] op);
		unique case (cmlb_cop_t'(op))
			C_EQ: cond_cmp = (a == b);
			C_NE: cond_cmp = (a != b);
			C_GT: cond_cmp = (a > b);
			C_GE: cond_cmp = (a >= b);
			C_LT: cond_cmp = (a < b);
			C_LE: cond_cmp = (a <= b);
			C_OR: cond_cmp = (a != 16'h0000) | (b != 16'h0000);
			C_AND: cond_cmp = (a != 16'h0000) & (b != 16'h0000);
		endcase
	endfunction : cond_cmp

	function automatic logic comb_op(input logic c1, input logic c2, input logic [1:0] op);
		case (cmlb_comb_t'(op))
			CB_OR: comb_op = c1 | c2;
			CB_AND: comb_op = c1 & c2;
			CB_XOR: comb_op = c1 ^ c2;
			default: comb_op = 1'b0;
		endcase
	endfunction : comb_op

	function automatic logic stage_act(input logic [31:0] w, input cmlb_fault_t f, input cmlb_src_t v);
		logic [3:0] s;
		logic [3:0] k;
		s = w[`CMLB_F_SRC];
		k = s - 4'h7;
		stage_act = 1'b0;
		if (s >= 4'h1 && s <= 4'h6) begin
			stage_act = f[3'(s - 4'h1)];
		end else if (s >= 4'h7 && s <= 4'hE) begin
			stage_act = (v[k[2:0]] >= w[`CMLB_F_HI]);
		end
	endfunction : stage_act

	function automatic logic [2:0] pick(input logic [N_STAGE-1:0] act);
		pick = 3'h0;
		for (int s = N_STAGE - 1; s >= 0; s--) begin
			if (act[s]) begin
				pick = 3'(s + 1);
			end
		end
	endfunction : pick

	function automatic cmlb_dec_t dec(input logic [31:0] a);
		dec = '{kind: RK_NONE, blk: 1'b0, idx: 2'h0};
		for (int b = 0; b < N_MATH; b++) begin
			for (int i = 0; i < N_IN; i++) begin
				if (a == `CMLB_MATH_BASE + 32'(b) * `CMLB_MATH_SPAN + 32'(i) * `CMLB_IN_STEP) begin
					dec = '{kind: RK_LIM, blk: 1'(b), idx: 2'(i)};
				end
				if (a == `CMLB_MATH_BASE + 32'(b) * `CMLB_MATH_SPAN + 32'(i) * `CMLB_IN_STEP + `CMLB_IN_CFG) begin
					dec = '{kind: RK_CFG, blk: 1'(b), idx: 2'(i)};
				end
			end
			if (a == `CMLB_MATH_BASE + 32'(b) * `CMLB_MATH_SPAN + `CMLB_OPS) begin
				dec = '{kind: RK_OPS, blk: 1'(b), idx: 2'h0};
			end
			if (a == `CMLB_MATH_BASE + 32'(b) * `CMLB_MATH_SPAN + `CMLB_ORNG) begin
				dec = '{kind: RK_ORNG, blk: 1'(b), idx: 2'h0};
			end
		end
		for (int c = 0; c < N_COND; c++) begin
			if (a == `CMLB_COND_BASE + 32'(c) * `CMLB_WORD) begin
				dec = '{kind: RK_COND, blk: 1'(c), idx: 2'h0};
			end
		end
		for (int l = 0; l < N_LED; l++) begin
			for (int s = 0; s < N_STAGE; s++) begin
				if (a == `CMLB_LED_BASE + 32'(l) * `CMLB_LED_SPAN + 32'(s) * `CMLB_WORD) begin
					dec = '{kind: RK_LED, blk: 1'(l), idx: 2'(s)};
				end
			end
		end
		if (a == `CMLB_STAT_MATH) begin
			dec = '{kind: RK_STAT, blk: 1'b0, idx: 2'h0};
		end
		if (a == `CMLB_STAT_FLAGS) begin
			dec = '{kind: RK_STAT, blk: 1'b0, idx: 2'h1};
		end
	endfunction : dec

	function automatic logic [31:0] reg_read(input cmlb_dec_t d);
		reg_read = 32'h0000_0000;
		case (d.kind)
			RK_LIM: reg_read = lim_ff[d.blk][d.idx];
			RK_CFG: reg_read = icfg_ff[d.blk][d.idx];
			RK_OPS: reg_read = ops_ff[d.blk];
			RK_ORNG: reg_read = orng_ff[d.blk];
			RK_COND: reg_read = cond_ff[d.blk];
			RK_LED: reg_read = stg_ff[d.blk][d.idx];
			RK_STAT: begin
				if (d.idx == 2'h0) begin
					reg_read = {math_ff[1], math_ff[0]};
				end else begin
					reg_read[`CMLB_F_COUT] = cout_ff;
					reg_read[`CMLB_F_LS0] = lstage_ff[0];
					reg_read[`CMLB_F_LS1] = lstage_ff[1];
				end
			end
			default: reg_read = 32'h0000_0000;
		endcase
	endfunction : reg_read

	// ----------------------------------------
	// Math blocks
	// ----------------------------------------
	cmlb_mout_t nxt_math;
	genvar gb, gi;
	for (gb = 0; gb < N_MATH; gb++) begin : g_math
		wire logic [N_IN-1:0][31:0] opd;
		wire logic [N_IN-1:0] used;
		wire logic [N_FN:0][31:0] res;
		for (gi = 0; gi < N_IN; gi++) begin : g_in
			assign used[gi] = (icfg_ff[gb][gi][`CMLB_F_SRC] != 4'h0);
			assign opd[gi] = !used[gi] ? 32'h0000_0000 : 32'(weight(to_pct(
				sel_src(icfg_ff[gb][gi][`CMLB_F_SRC], src_val),
				lim_ff[gb][gi][`CMLB_F_LO], lim_ff[gb][gi][`CMLB_F_HI]),
				icfg_ff[gb][gi][`CMLB_F_HI]));
		end
		assign res[0] = opd[0];
		for (gi = 0; gi < N_FN; gi++) begin : g_fn
			assign res[gi+1] = 32'(math_fn(res[gi], opd[gi+1],
				ops_ff[gb][gi*`CMLB_OP_W +: `CMLB_OP_W], used[gi+1]));
		end
		assign nxt_math[gb] = to_phys(res[N_FN], orng_ff[gb][`CMLB_F_LO], orng_ff[gb][`CMLB_F_HI]);
	end

	// ----------------------------------------
	// Conditional blocks
	// ----------------------------------------
	cmlb_cout_t nxt_cout;
	genvar gc;
	for (gc = 0; gc < N_COND; gc++) begin : g_cond
		wire logic [N_IN-1:0][15:0] cv;
		wire logic c1;
		wire logic c2;
		for (gi = 0; gi < N_IN; gi++) begin : g_cin
			assign cv[gi] = sel_src(cond_ff[gc][gi*`CMLB_SRC_W +: `CMLB_SRC_W], src_val);
		end
		assign c1 = cond_cmp(cv[0], cv[1], cond_ff[gc][`CMLB_F_C1]);
		assign c2 = cond_cmp(cv[2], cv[3], cond_ff[gc][`CMLB_F_C2]);
		assign nxt_cout[gc] = comb_op(c1, c2, cond_ff[gc][`CMLB_F_C3]);
	end

	// ----------------------------------------
	// LED stages
	// ----------------------------------------
	cmlb_lstage_t nxt_lstage;
	genvar gl, gs;
	for (gl = 0; gl < N_LED; gl++) begin : g_led
		wire logic [N_STAGE-1:0] act;
		for (gs = 0; gs < N_STAGE; gs++) begin : g_stg
			assign act[gs] = stage_act(stg_ff[gl][gs], fault_in, src_val);
		end
		assign nxt_lstage[gl] = pick(act);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			math_ff <= '0;
			cout_ff <= '0;
			lstage_ff <= '0;
		end else begin
			math_ff <= nxt_math;
			cout_ff <= nxt_cout;
			lstage_ff <= nxt_lstage;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	wire cmlb_dec_t wd = dec(awaddr_ff);
	wire cmlb_dec_t rd = dec(axil_req.araddr);
	wire logic do_wr = aw_have_ff & w_have_ff;
	wire logic [31:0] wword = merge(reg_read(wd), wdata_ff, wstrb_ff);
	// An illegal combining code is refused whole, keeping the old word
	wire logic bad_comb = (wd.kind == RK_COND) && (wword[`CMLB_F_C3] > CB_XOR);
	wire logic wr_ok = do_wr && !bad_comb && wd.kind != RK_NONE && wd.kind != RK_STAT;
	wire logic aw_take = axil_req.awvalid & rsp_ff.awready;
	wire logic w_take = axil_req.wvalid & rsp_ff.wready;
	wire logic ar_take = axil_req.arvalid & rsp_ff.arready;
	wire logic nxt_aw_have = (aw_have_ff | aw_take) & ~do_wr;
	wire logic nxt_w_have = (w_have_ff | w_take) & ~do_wr;

	always_comb begin
		nxt_rsp = rsp_ff;
		nxt_rsp.bvalid = do_wr | (rsp_ff.bvalid & ~axil_req.bready);
		nxt_rsp.awready = ~nxt_aw_have & ~nxt_rsp.bvalid;
		nxt_rsp.wready = ~nxt_w_have & ~nxt_rsp.bvalid;
		nxt_rsp.rvalid = ar_take | (rsp_ff.rvalid & ~axil_req.rready);
		nxt_rsp.arready = ~nxt_rsp.rvalid;
		if (do_wr) begin
			nxt_rsp.bresp = wr_ok ? `CMLB_RESP_OKAY : `CMLB_RESP_SLVERR;
		end
		if (ar_take) begin
			nxt_rsp.rdata = reg_read(rd);
			nxt_rsp.rresp = (rd.kind == RK_NONE) ? `CMLB_RESP_SLVERR : `CMLB_RESP_OKAY;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_ff <= '0;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			rsp_ff <= nxt_rsp;
			aw_have_ff <= nxt_aw_have;
			w_have_ff <= nxt_w_have;
			awaddr_ff <= aw_take ? axil_req.awaddr : awaddr_ff;
			wdata_ff <= w_take ? axil_req.wdata : wdata_ff;
			wstrb_ff <= w_take ? axil_req.wstrb : wstrb_ff;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int b = 0; b < N_MATH; b++) begin
				for (int i = 0; i < N_IN; i++) begin
					lim_ff[b][i] <= `CMLB_LIM_RST;
					icfg_ff[b][i] <= `CMLB_ICFG_RST;
				end
				ops_ff[b] <= `CMLB_OPS_RST;
				orng_ff[b] <= `CMLB_ORNG_RST;
			end
			for (int c = 0; c < N_COND; c++) begin
				cond_ff[c] <= `CMLB_COND_RST;
			end
			for (int l = 0; l < N_LED; l++) begin
				for (int s = 0; s < N_STAGE; s++) begin
					stg_ff[l][s] <= `CMLB_LED_RST;
				end
			end
		end else if (wr_ok) begin
			case (wd.kind)
				RK_LIM: lim_ff[wd.blk][wd.idx] <= wword;
				RK_CFG: icfg_ff[wd.blk][wd.idx] <= wword;
				RK_OPS: ops_ff[wd.blk] <= wword;
				RK_ORNG: orng_ff[wd.blk] <= wword;
				RK_COND: cond_ff[wd.blk] <= wword;
				RK_LED: stg_ff[wd.blk][wd.idx] <= wword;
				default: ;
			endcase
		end
	end

	assign axil_rsp = rsp_ff;
	assign math_out = math_ff;
	assign cond_out = cout_ff;
	assign led_stage = lstage_ff;

endmodule : cmlb_top
`default_nettype wire

// ===== dv/cmlb_src_model.sv
// Model of the setpoints and function blocks feeding the evaluation block
`timescale 1ns/100ps
`default_nettype none
module cmlb_src_model (
	input wire logic aclk,
	output var cmlb_pkg::cmlb_src_t src_val,
	output var cmlb_pkg::cmlb_fault_t fault_in
);
	import cmlb_pkg::*;
	// ----------------------------------------
	// Sources hold until told otherwise
	// ----------------------------------------
	initial begin
		src_val = '0;
		fault_in = '0;
	end
	// Changes land just after an edge so the design samples a settled value
	// Static so the index may feed a non-blocking write
	task put(input int k, input logic [15:0] v);
		@(posedge aclk);
		src_val[k] <= v;
	endtask : put
	task flt(input logic [5:0] v);
		@(posedge aclk);
		fault_in <= v;
	endtask : flt
endmodule : cmlb_src_model
`default_nettype wire

// ===== dv/cmlb_monitor.sv
// Concurrent checks on the ports of the evaluation block
`timescale 1ns/100ps
`default_nettype none
module cmlb_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cmlb_pkg::cmlb_axil_req_t axil_req,
	input wire cmlb_pkg::cmlb_axil_rsp_t axil_rsp,
	input wire cmlb_pkg::cmlb_src_t src_val,
	input wire cmlb_pkg::cmlb_fault_t fault_in,
	input wire cmlb_pkg::cmlb_mout_t math_out,
	input wire cmlb_pkg::cmlb_cout_t cond_out,
	input wire cmlb_pkg::cmlb_lstage_t led_stage
);
	import cmlb_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Outputs move only with inputs or config
	// ----------------------------------------
	// A write edge shows as bvalid one cycle later, so bvalid masks it
	property p_quiet_math;
		$stable(src_val) && !axil_rsp.bvalid |=> $stable(math_out);
	endproperty
	a_quiet_math: assert property (p_quiet_math) else $error("math moved, inputs held");
	property p_quiet_cond;
		$stable(src_val) && !axil_rsp.bvalid |=> $stable(cond_out);
	endproperty
	a_quiet_cond: assert property (p_quiet_cond) else $error("cond moved, inputs held");
	property p_quiet_led;
		$stable(src_val) && $stable(fault_in) && !axil_rsp.bvalid |=> $stable(led_stage);
	endproperty
	a_quiet_led: assert property (p_quiet_led) else $error("led moved, inputs held");
	property p_led_range;
		led_stage[0] <= 3'h4 && led_stage[1] <= 3'h4;
	endproperty
	a_led_range: assert property (p_led_range) else $error("led stage out of range");
	// ----------------------------------------
	// Reset defaults and status words
	// ----------------------------------------
	property p_rst_led;
		$rose(aresetn) |-> (cond_out == 2'h0 && led_stage == 6'h00)[*2];
	endproperty
	a_rst_led: assert property (p_rst_led) else $error("cond or led not idle after reset");
	property p_rst_math;
		$rose(aresetn) |-> (math_out == 32'h0)[*2];
	endproperty
	a_rst_math: assert property (p_rst_math) else $error("math not zero after reset");
	property p_stat_c4;
		axil_req.arvalid && axil_rsp.arready && axil_req.araddr == 32'hC4 |=>
			axil_rsp.rdata[10:0] == {$past(led_stage[1]), 1'h0, $past(led_stage[0]), 2'h0, $past(cond_out)};
	endproperty
	a_stat_c4: assert property (p_stat_c4) else $error("flag status word wrong");
	property p_stat_c0;
		axil_req.arvalid && axil_rsp.arready && axil_req.araddr == 32'hC0 |=> axil_rsp.rdata == $past(math_out);
	endproperty
	a_stat_c0: assert property (p_stat_c0) else $error("math status word wrong");
endmodule : cmlb_monitor
bind cmlb_top cmlb_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
	.src_val(src_val), .fault_in(fault_in), .math_out(math_out), .cond_out(cond_out), .led_stage(led_stage));
`default_nettype wire

// ===== dv/cmlb_tb.sv
// Self-checking bench for the math, conditional and LED evaluation block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import cmlb_pkg::*;
	logic aclk;
	logic aresetn;
	cmlb_axil_req_t req;
	cmlb_axil_rsp_t rsp;
	cmlb_src_t src_val;
	cmlb_fault_t fault_in;
	cmlb_mout_t math_out;
	cmlb_cout_t cond_out;
	cmlb_lstage_t led_stage;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	// ----------------------------------------
	// Expected results, A = 60 against B = 30, 80, 0
	// ----------------------------------------
	logic [7:0] mx [45] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h5A, 8'h1E, 8'h12,
		8'h64, 8'h1E, 8'h3C, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h64, 8'h00, 8'h30,
		8'h4B, 8'h3C, 8'h50, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h3C, 8'h3C, 8'h00,
		8'h64, 8'h00, 8'h3C};
	logic [15:0] bv [3] = '{16'h1E, 16'h50, 16'h00};
	logic [15:0] cv [4] = '{16'h28, 16'h1E, 16'h32, 16'h19};
	logic [15:0] lv [4] = '{16'h3B, 16'h3C, 16'h3C, 16'h32};
	logic [5:0] lf [4] = '{6'h00, 6'h00, 6'h04, 6'h04};
	logic [2:0] le [4] = '{3'h0, 3'h3, 3'h1, 3'h1};
	logic [7:0] ce = 8'hCE;
	logic [5:0] cc = 6'h1D;
	cmlb_top i_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .src_val(src_val),
		.fault_in(fault_in), .math_out(math_out), .cond_out(cond_out), .led_stage(led_stage));
	cmlb_src_model i_src (.aclk(aclk), .src_val(src_val), .fault_in(fault_in));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= v;
		req.bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'h0;
			if (rsp.wready) req.wvalid <= 1'h0;
		end while (rsp.bvalid !== 1'h1);
		req.bready <= 1'h0;
		chk({30'h0, rsp.bresp}, {30'h0, er});
		cyc(2);
	endtask : wr
	task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'h0;
		end while (rsp.rvalid !== 1'h1);
		req.rready <= 1'h0;
		chk(rsp.rdata, e);
		chk({30'h0, rsp.rresp}, {30'h0, er});
	endtask : rdc
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// Generous ceiling, the sequence needs under a thousand cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		req = '0;
		req.wstrb = 4'hF;
		aresetn = 1'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		cyc(2);
		rdc(32'h84, 32'h0077_0000, 2'h0);
		rdc(32'h44, 32'h4000_0000, 2'h0);
		rdc(32'h100, 32'h0, 2'h2);
		wr(32'hC0, 32'hFFFF, 2'h2);
		done("reset");
		i_src.put(0, 16'h3C);
		wr(32'h04, 32'h4000_0001, 2'h0);
		wr(32'h0C, 32'h4000_0002, 2'h0);
		for (int i = 0; i < 45; i++) begin
			if (i % 15 == 0) i_src.put(1, bv[i / 15]);
			wr(32'h20, 32'(i % 15), 2'h0);
			chk({16'h0, math_out[0]}, {24'h0, mx[i]});
		end
		wr(32'h0C, 32'h4000_0000, 2'h0);
		wr(32'h20, 32'hB, 2'h0);
		chk({16'h0, math_out[0]}, 32'h3C);
		wr(32'h04, 32'h2000_0001, 2'h0);
		chk({16'h0, math_out[0]}, 32'h1E);
		wr(32'h04, 32'hC000_0001, 2'h0);
		chk({16'h0, math_out[0]}, 32'h0);
		wr(32'h04, 32'h4000_0001, 2'h0);
		wr(32'h00, 32'h00DC_0014, 2'h0);
		i_src.put(0, 16'h78);
		cyc(2);
		chk({16'h0, math_out[0]}, 32'h32);
		wr(32'h24, 32'h07D0_03E8, 2'h0);
		chk({16'h0, math_out[0]}, 32'h5DC);
		for (int k = 0; k < 4; k++) begin
			i_src.put(k + 2, cv[k]);
			wr(32'h44 + 32'(k * 8), 32'h4000_0003 + 32'(k), 2'h0);
		end
		wr(32'h60, 32'hDA9, 2'h0);
		chk({16'h0, math_out[1]}, 32'h14);
		done("math");
		i_src.put(1, 16'h1E);
		for (int o = 0; o < 8; o++) begin
			wr(32'h80, 32'h0010_0021 | (32'(o) << 16), 2'h0);
			chk({31'h0, cond_out[0]}, {31'h0, ce[o]});
		end
		for (int j = 0; j < 6; j++) begin
			wr(32'h80, 32'h0001_0021 | (32'(1 - j / 3) << 20) | (32'(j % 3) << 24), 2'h0);
			chk({31'h0, cond_out[0]}, {31'h0, cc[j]});
		end
		wr(32'h80, 32'h0300_0021, 2'h2);
		rdc(32'h80, 32'h0201_0021, 2'h0);
		// Byte lane 2 only; GE keeps the condition result unchanged
		req.wstrb <= 4'h4;
		wr(32'h80, 32'hFF03_FFFF, 2'h0);
		req.wstrb <= 4'hF;
		rdc(32'h80, 32'h0203_0021, 2'h0);
		chk({31'h0, cond_out[0]}, 32'h0);
		chk({31'h0, cond_out[1]}, 32'h0);
		done("cond");
		wr(32'hA0, 32'h3, 2'h0);
		wr(32'hA8, 32'h003C_0007, 2'h0);
		for (int s = 0; s < 4; s++) begin
			i_src.put(0, lv[s]);
			i_src.flt(lf[s]);
			cyc(2);
			chk({29'h0, led_stage[0]}, {29'h0, le[s]});
		end
		for (int k = 1; k < 7; k++) begin
			wr(32'hBC, 32'(k), 2'h0);
			i_src.flt(~(6'h01 << (k - 1)));
			cyc(2);
			chk({29'h0, led_stage[1]}, 32'h0);
			i_src.flt(6'h01 << (k - 1));
			cyc(2);
			chk({29'h0, led_stage[1]}, 32'h4);
		end
		rdc(32'hC4, 32'h400, 2'h0);
		rdc(32'hC0, 32'h0014_047E, 2'h0);
		done("led");
		aresetn <= 1'h0;
		cyc(3);
		aresetn <= 1'h1;
		cyc(2);
		rdc(32'h80, 32'h0077_0000, 2'h0);
		done("second reset");
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
